// ==== rtl/rft_pkg.sv ====
package rft_pkg;
  // command codes and answer codes on the link
  localparam logic [7:0] RFT_CMD_PROTO     = 8'h02;
  localparam logic [7:0] RFT_CMD_REG_WRITE = 8'h09;
  localparam logic [7:0] RFT_RES_OK        = 8'h00;
  localparam logic [7:0] RFT_RES_ERR       = 8'h82;
  localparam logic [7:0] RFT_LEN_SHORT     = 8'h03;
  localparam logic [7:0] RFT_LEN_LONG      = 8'h04;
  localparam logic [7:0] RFT_LEN_PROTO     = 8'h02;
  localparam logic [7:0] RFT_INC_FLAG      = 8'h01;
  // register addresses, indexes and confirmation bytes
  localparam logic [7:0] RFT_ADDR_FILTER   = 8'h0a;
  localparam logic [7:0] RFT_ADDR_WINDOW   = 8'h3a;
  localparam logic [7:0] RFT_ADDR_ANALOG   = 8'h68;
  localparam logic [7:0] RFT_IDX_ANALOG    = 8'h01;
  localparam logic [7:0] RFT_IDX_CUT       = 8'h07;
  localparam logic [7:0] RFT_CONF_WINDOW   = 8'h04;
  localparam logic [7:0] RFT_CONF_FILTER   = 8'ha1;
  localparam logic [7:0] RFT_FILTER_ON     = 8'h02;
  localparam int         RFT_CUT_POS       = 4;
  // window default and host-side limits
  localparam logic [7:0] RFT_WINDOW_RESET  = 8'h52;
  localparam logic [7:0] RFT_WINDOW_MIN    = 8'h50;
  localparam logic [7:0] RFT_WINDOW_MAX    = 8'h60;
  // protocol codes and per-protocol analog defaults
  localparam logic [7:0] RFT_P_15693       = 8'h01;
  localparam logic [7:0] RFT_P_14443A      = 8'h02;
  localparam logic [7:0] RFT_P_14443B      = 8'h03;
  localparam logic [7:0] RFT_P_18092       = 8'h04;
  localparam int         RFT_DEPTH_POS     = 4;
  localparam logic [7:0] RFT_ARC_14443A    = 8'hdf;
  localparam logic [7:0] RFT_ARC_14443B    = 8'h2f;
  localparam logic [7:0] RFT_ARC_18092     = 8'h5f;
  localparam logic [7:0] RFT_ARC_15693_30  = 8'h53;
  localparam logic [7:0] RFT_ARC_15693_100 = 8'hd3;
  localparam logic [7:0] RFT_ARC_RESET     = 8'hdf;
  // host register map (AXI4-Lite byte addresses)
  localparam logic [3:0] RFT_REG_CMD       = 4'h0;
  localparam logic [3:0] RFT_REG_DATA      = 4'h4;
  localparam logic [3:0] RFT_REG_CTRL      = 4'h8;
  localparam logic [3:0] RFT_REG_STATUS    = 4'hc;
  localparam logic [1:0] RFT_RESP_OKAY     = 2'b00;
  localparam logic [1:0] RFT_RESP_SLVERR   = 2'b10;
endpackage

// ==== rtl/rft_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface rft_link_if (
  input wire logic aclk,
  input wire logic aresetn
);
  logic       cmd_valid;
  logic       cmd_ready;
  logic [7:0] cmd_byte;
  logic       rsp_valid;
  logic       rsp_ready;
  logic [7:0] rsp_byte;
  modport dev  (input cmd_valid, cmd_byte, rsp_ready, output cmd_ready, rsp_valid, rsp_byte);
  modport host (output cmd_valid, cmd_byte, rsp_ready, input cmd_ready, rsp_valid, rsp_byte);
endinterface
`default_nettype wire

// ==== rtl/rft_device.sv ====
// Contract
// - protocol select loads per-protocol analog default
// - 14443-A: modulation D, legal gain nibbles
// - 14443-B: modulation 1..4, legal gain nibbles
// - host keeps window within 0x50..0x60
// - protocol select sets window to 0x52
// - window write: 09,len,3A,flag,value,04
// - protocol select disables the sync filter
// - filter write: 09,len,0A,flag,02,A1 enables
// - cut bit set blocks reader mode
// - cut cleared by zero write or select
// - cut write: 68,flag,07,data 10/00
// - length 03 or 04; flag 01 advances
// - good write answers 00 then 00
// - analog byte at 68 index 01, nibbles
// - analog value holds until select or write
`timescale 1ns/1ps
`default_nettype none
module rft_device
  import rft_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  rft_link_if.dev         link,
  output logic [7:0]      analog_config_byte,
  output logic [7:0]      demod_timing_window,
  output logic            sync_assist_filter,
  output logic            tx_supply_cut_bit,
  output logic            reader_mode_en,
  output logic [7:0]      protocol
);

  typedef enum logic [2:0] {
    S_CODE,
    S_LEN,
    S_BODY,
    S_EXEC,
    S_RSP_CODE,
    S_RSP_LEN
  } rft_dev_state_t;

  typedef struct packed {
    rft_dev_state_t  st;
    logic [7:0]      code;
    logic [7:0]      len;
    logic [7:0]      cnt;
    logic [3:0][7:0] body;
    logic [7:0]      result;
    logic [7:0]      analog;
    logic [7:0]      window;
    logic            filter;
    logic            cut;
    logic [7:0]      index;
    logic [7:0]      proto;
  } rft_dev_s_t;

  rft_dev_s_t s;
  rft_dev_s_t next_s;

  logic       take;
  logic       give;
  logic       proto_ok;
  logic [7:0] proto_arc;
  logic [7:0] next_cnt;

  assign link.cmd_ready = (s.st == S_CODE) || (s.st == S_LEN) || (s.st == S_BODY);
  assign link.rsp_valid = (s.st == S_RSP_CODE) || (s.st == S_RSP_LEN);
  // answer length is always zero: no command here returns data
  assign link.rsp_byte  = (s.st == S_RSP_CODE) ? s.result : 8'h00;
  assign take           = link.cmd_valid && link.cmd_ready;
  assign give           = link.rsp_valid && link.rsp_ready;
  assign next_cnt       = s.cnt + 8'h01;

  always_comb begin
    proto_ok  = 1'b1;
    proto_arc = RFT_ARC_RESET;
    case (s.body[0])
      RFT_P_14443A: proto_arc = RFT_ARC_14443A;
      RFT_P_14443B: proto_arc = RFT_ARC_14443B;
      RFT_P_18092:  proto_arc = RFT_ARC_18092;
      RFT_P_15693: begin
        // depth bit in the parameter byte picks the 30 % default
        proto_arc = s.body[1][RFT_DEPTH_POS] ? RFT_ARC_15693_30 : RFT_ARC_15693_100;
      end
      default: proto_ok = 1'b0;
    endcase
  end

  always_comb begin
    next_s = s;
    case (s.st)
      S_CODE: begin
        if (take) begin
          next_s.code = link.cmd_byte;
          next_s.st   = S_LEN;
        end
      end
      S_LEN: begin
        if (take) begin
          next_s.len = link.cmd_byte;
          next_s.cnt = 8'h00;
          next_s.st  = (link.cmd_byte == 8'h00) ? S_EXEC : S_BODY;
        end
      end
      S_BODY: begin
        if (take) begin
          // only the first four bytes matter; longer bodies are drained
          if (s.cnt < 8'h04) begin
            next_s.body[s.cnt[1:0]] = link.cmd_byte;
          end
          next_s.cnt = next_cnt;
          if (next_cnt == s.len) begin
            next_s.st = S_EXEC;
          end
        end
      end
      S_EXEC: begin
        next_s.result = RFT_RES_ERR;
        next_s.st     = S_RSP_CODE;
        if (s.code == RFT_CMD_PROTO) begin
          if ((s.len >= RFT_LEN_PROTO) && proto_ok) begin
            next_s.result = RFT_RES_OK;
            next_s.proto  = s.body[0];
            next_s.analog = proto_arc;
            next_s.window = RFT_WINDOW_RESET;
            next_s.filter = 1'b0;
            next_s.cut    = 1'b0;
          end
        end else if (s.code == RFT_CMD_REG_WRITE) begin
          // any other length falls through with the error code, state untouched
          if ((s.len == RFT_LEN_SHORT) || (s.len == RFT_LEN_LONG)) begin
            case (s.body[0])
              RFT_ADDR_ANALOG: begin
                next_s.result = RFT_RES_OK;
                if (s.len == RFT_LEN_SHORT) begin
                  next_s.index = s.body[2];
                end else begin
                  if (s.body[2] == RFT_IDX_ANALOG) begin
                    next_s.analog = s.body[3];
                  end else if (s.body[2] == RFT_IDX_CUT) begin
                    next_s.cut = s.body[3][RFT_CUT_POS];
                  end
                  next_s.index = (s.body[1] == RFT_INC_FLAG) ? s.body[2] + 8'h01 : s.body[2];
                end
              end
              RFT_ADDR_WINDOW: begin
                if ((s.len == RFT_LEN_LONG) && (s.body[3] == RFT_CONF_WINDOW)) begin
                  next_s.result = RFT_RES_OK;
                  next_s.window = s.body[2];
                end
              end
              RFT_ADDR_FILTER: begin
                if ((s.len == RFT_LEN_LONG) && (s.body[3] == RFT_CONF_FILTER)) begin
                  next_s.result = RFT_RES_OK;
                  next_s.filter = (s.body[2] == RFT_FILTER_ON);
                end
              end
              default: next_s.result = RFT_RES_ERR;
            endcase
          end
        end
      end
      S_RSP_CODE: begin
        if (give) begin
          next_s.st = S_RSP_LEN;
        end
      end
      S_RSP_LEN: begin
        if (give) begin
          next_s.st = S_CODE;
        end
      end
      default: next_s.st = S_CODE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s        <= '0;
      s.st     <= S_CODE;
      s.analog <= RFT_ARC_RESET;
      s.window <= RFT_WINDOW_RESET;
      s.cut    <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign analog_config_byte  = s.analog;
  assign demod_timing_window = s.window;
  assign sync_assist_filter  = s.filter;
  assign tx_supply_cut_bit   = s.cut;
  // the supply cut and reader mode are one flop; they cannot disagree
  assign reader_mode_en      = !s.cut;
  assign protocol            = s.proto;

endmodule
`default_nettype wire

// ==== rtl/rft_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module rft_host
  import rft_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  rft_link_if.host         link,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  typedef enum logic [2:0] {
    H_IDLE,
    H_CODE,
    H_LEN,
    H_BODY,
    H_RCODE,
    H_RLEN,
    H_SKIP
  } rft_host_state_t;

  typedef struct packed {
    rft_host_state_t st;
    logic            aw_got;
    logic [3:0]      awaddr;
    logic            w_got;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic [15:0]     cmd;
    logic [31:0]     data;
    logic [7:0]      cnt;
    logic            done;
    logic            refused;
    logic [7:0]      result;
    logic [7:0]      rlen;
    logic [7:0]      proto;
    logic            depth30;
  } rft_host_s_t;

  rft_host_s_t s;
  rft_host_s_t next_s;

  logic [31:0] mask;
  logic [7:0]  b0;
  logic [7:0]  b2;
  logic [7:0]  b3;
  logic        gain_ok;
  logic        mod_ok;
  logic        bad;

  assign b0 = s.data[7:0];
  assign b2 = s.data[23:16];
  assign b3 = s.data[31:24];

  always_comb begin
    mask    = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
    gain_ok = (b3[3:0] == 4'h0) || (b3[3:0] == 4'h1) || (b3[3:0] == 4'h3)
           || (b3[3:0] == 4'h7) || (b3[3:0] == 4'hf);
    case (s.proto)
      RFT_P_14443A: mod_ok = (b3[7:4] == 4'hd);
      RFT_P_14443B: mod_ok = (b3[7:4] >= 4'h1) && (b3[7:4] <= 4'h4);
      RFT_P_18092:  mod_ok = (b3[7:4] >= 4'h1) && (b3[7:4] <= 4'h4);
      RFT_P_15693:  mod_ok = s.depth30 ? ((b3[7:4] >= 4'h4) && (b3[7:4] <= 4'h6))
                                       : (b3[7:4] == 4'hd);
      default:      mod_ok = 1'b1;
    endcase
    bad = 1'b0;
    if (s.cmd[7:0] == RFT_CMD_REG_WRITE) begin
      if ((s.cmd[15:8] != RFT_LEN_SHORT) && (s.cmd[15:8] != RFT_LEN_LONG)) begin
        bad = 1'b1;
      end else if (s.cmd[15:8] == RFT_LEN_LONG) begin
        if ((b0 == RFT_ADDR_ANALOG) && (b2 == RFT_IDX_ANALOG) && !(gain_ok && mod_ok)) begin
          bad = 1'b1;
        end
        if ((b0 == RFT_ADDR_WINDOW) && ((b2 < RFT_WINDOW_MIN) || (b2 > RFT_WINDOW_MAX))) begin
          bad = 1'b1;
        end
      end
    end
  end

  assign s_axi_awready  = !s.aw_got && !s.bvalid;
  assign s_axi_wready   = !s.w_got && !s.bvalid;
  assign s_axi_arready  = !s.rvalid;
  assign link.cmd_valid = (s.st == H_CODE) || (s.st == H_LEN) || (s.st == H_BODY);
  assign link.rsp_ready = (s.st == H_RCODE) || (s.st == H_RLEN) || (s.st == H_SKIP);

  always_comb begin
    next_s = s;
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = RFT_RESP_OKAY;
      case ({s.awaddr[3:2], 2'b00})
        RFT_REG_CMD:  next_s.cmd  = s.cmd & ~mask[15:0] | s.wdata[15:0] & mask[15:0];
        RFT_REG_DATA: next_s.data = s.data & ~mask | s.wdata & mask;
        RFT_REG_CTRL: begin
          // a start while busy is dropped: one command on the link at a time
          if (s.wstrb[0] && s.wdata[0] && (s.st == H_IDLE)) begin
            next_s.done    = 1'b0;
            next_s.refused = bad;
            next_s.st      = bad ? H_IDLE : H_CODE;
            next_s.cnt     = 8'h00;
          end
        end
        default: next_s.bresp = RFT_RESP_SLVERR;
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RFT_RESP_OKAY;
      case ({s_axi_araddr[3:2], 2'b00})
        RFT_REG_CMD:    next_s.rdata = {16'h0000, s.cmd};
        RFT_REG_DATA:   next_s.rdata = s.data;
        RFT_REG_CTRL:   next_s.rdata = 32'h0000_0000;
        RFT_REG_STATUS: next_s.rdata = {8'h00, s.rlen, s.result, 5'h00, s.refused, s.done,
                                        (s.st != H_IDLE)};
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = RFT_RESP_SLVERR;
        end
      endcase
    end
    case (s.st)
      H_IDLE: next_s.st = next_s.st;
      H_CODE: begin
        if (link.cmd_ready) begin
          next_s.st = H_LEN;
        end
      end
      H_LEN: begin
        if (link.cmd_ready) begin
          next_s.st = (s.cmd[15:8] == 8'h00) ? H_RCODE : H_BODY;
        end
      end
      H_BODY: begin
        if (link.cmd_ready) begin
          next_s.cnt = s.cnt + 8'h01;
          if (s.cnt + 8'h01 == s.cmd[15:8]) begin
            next_s.st = H_RCODE;
          end
        end
      end
      H_RCODE: begin
        if (link.rsp_valid) begin
          next_s.result = link.rsp_byte;
          next_s.st     = H_RLEN;
        end
      end
      H_RLEN: begin
        if (link.rsp_valid) begin
          next_s.rlen = link.rsp_byte;
          next_s.cnt  = 8'h00;
          if (link.rsp_byte == 8'h00) begin
            next_s.st   = H_IDLE;
            next_s.done = 1'b1;
            // protocol is tracked only once the device has accepted it
            if ((s.cmd[7:0] == RFT_CMD_PROTO) && (s.result == RFT_RES_OK)) begin
              next_s.proto   = b0;
              next_s.depth30 = s.data[8 + RFT_DEPTH_POS];
            end
          end else begin
            next_s.st = H_SKIP;
          end
        end
      end
      H_SKIP: begin
        if (link.rsp_valid) begin
          next_s.cnt = s.cnt + 8'h01;
          if (s.cnt + 8'h01 == s.rlen) begin
            next_s.st   = H_IDLE;
            next_s.done = 1'b1;
          end
        end
      end
      default: next_s.st = H_IDLE;
    endcase
  end

  always_comb begin
    case (s.st)
      H_CODE:  link.cmd_byte = s.cmd[7:0];
      H_LEN:   link.cmd_byte = s.cmd[15:8];
      H_BODY:  link.cmd_byte = (s.cnt < 8'h04) ? s.data[{s.cnt[1:0], 3'b000} +: 8] : 8'h00;
      default: link.cmd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s    <= '0;
      s.st <= H_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp  = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata  = s.rdata;
  assign s_axi_rresp  = s.rresp;

endmodule
`default_nettype wire

// ==== verif/rft_link_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module rft_link_properties (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic [7:0] cmd_byte,
  input wire logic       rsp_valid,
  input wire logic       rsp_ready,
  input wire logic [7:0] rsp_byte
);
  // frame capture, so each answer is judged against the bytes that caused it
  logic [8:0] pos;
  logic [7:0] code, len, b0, b3;
  logic       second;
  wire take  = cmd_valid && cmd_ready;
  wire first = rsp_valid && !second;
  wire last  = take && ((pos == 9'h001) ? (cmd_byte == 8'h00) :
                        (pos > 9'h001 && pos == {1'b0, len} + 9'h001));
  wire ok_wr = code == 8'h09 && ((len == 8'h03 && b0 == 8'h68) || (len == 8'h04 &&
               (b0 == 8'h68 || (b0 == 8'h3a && b3 == 8'h04) || (b0 == 8'h0a && b3 == 8'ha1))));
  wire ok_sel = code == 8'h02 && len >= 8'h02 && b0 >= 8'h01 && b0 <= 8'h04;
  wire bad_conf = code == 8'h09 && len == 8'h04 && b0 == 8'h3a && b3 != 8'h04;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos <= 9'h000;
      second <= 1'b0;
    end else begin
      if (take) begin
        pos <= pos + 9'h001;
        if (pos == 9'h000) code <= cmd_byte;
        if (pos == 9'h001) len <= cmd_byte;
        if (pos == 9'h002) b0 <= cmd_byte;
        if (pos == 9'h005) b3 <= cmd_byte;
      end
      if (rsp_valid && rsp_ready) begin
        second <= !second;
        if (second) pos <= 9'h000;
      end
    end
  end
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  good_write_a: assert property (first && ok_wr |-> rsp_byte == 8'h00)
    else $error("good write not answered with code zero");
  good_select_a: assert property (first && ok_sel |-> rsp_byte == 8'h00)
    else $error("good select not answered with code zero");
  bad_confirm_a: assert property (first && bad_conf |-> rsp_byte == 8'h82)
    else $error("wrong confirmation byte not refused");
  zero_length_a: assert property (rsp_valid && second |-> rsp_byte == 8'h00)
    else $error("answer length byte not zero");
  answer_delay_a: assert property (last |=> !rsp_valid ##1 rsp_valid)
    else $error("answer not on second edge after last byte");
  exec_busy_a: assert property (last |=> !cmd_ready [*2])
    else $error("command byte accepted while executing");
  // the paired host is always waiting when an answer byte appears
  answer_taken_a: assert property (rsp_valid |-> rsp_ready)
    else $error("answer byte offered while host not waiting");
  reopen_link_a: assert property (rsp_valid && rsp_ready && second |=> cmd_ready && !rsp_valid)
    else $error("link not reopened after answer");
  // the host only offers bytes once the device has reopened the link
  offer_taken_a: assert property (cmd_valid |-> cmd_ready)
    else $error("command byte offered while device busy");
  sel_seen_c: cover property (first && ok_sel);
  conf_err_c: cover property (first && bad_conf);
  burst_c: cover property (take ##1 take ##1 take);
endmodule
`default_nettype wire

// ==== verif/rf_tuning_register_writes_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module rf_tuning_register_writes_tb_top
  import rft_pkg::*;
;
  logic        aclk, aresetn;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, filt, cut, rmode;
  logic [7:0]  an, win, an2, win2, prot;
  logic [7:0]  q [$];
  int          n_fail, compares, seed, i, k, g, fl;
  int          m_an = 8'hdf, m_win = 8'h52, m_filt = 0, m_cut = 0, m_proto = 0;
  logic [7:0]  pr [5] = '{8'h02, 8'h03, 8'h04, 8'h01, 8'h01};
  logic [7:0]  pp [5] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
  logic [7:0]  gains [5] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0f};
  logic [7:0]  bad_len [5] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06};

  rft_link_if link (.aclk(aclk), .aresetn(aresetn));
  rft_link_if link2 (.aclk(aclk), .aresetn(aresetn));
  rft_device rft_device_inst (.aclk(aclk), .aresetn(aresetn), .link(link),
    .analog_config_byte(an), .demod_timing_window(win), .sync_assist_filter(filt),
    .tx_supply_cut_bit(cut), .reader_mode_en(rmode), .protocol(prot));
  // second device faces the bench directly, so framing faults can be sent on purpose
  rft_device rft_device_inst_b (.aclk(aclk), .aresetn(aresetn), .link(link2),
    .analog_config_byte(an2), .demod_timing_window(win2), .sync_assist_filter(),
    .tx_supply_cut_bit(), .reader_mode_en(), .protocol());
  rft_host rft_host_inst (.aclk(aclk), .aresetn(aresetn), .link(link),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  rft_link_properties rft_link_properties_inst (.aclk(aclk), .aresetn(aresetn),
    .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready), .cmd_byte(link.cmd_byte),
    .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready), .rsp_byte(link.rsp_byte));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 50) begin
      n_fail++;
      complete_run();
    end
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50 && !(aw_ok && w_ok); n++) begin
      @(posedge aclk);
      aw_ok = aw_ok || awready;
      w_ok = w_ok || wready;
      awvalid <= !aw_ok;
      wvalid <= !w_ok;
    end
    for (n = 0; n < 50 && !bvalid; n++) @(posedge aclk);
    tmo(n);
    bready <= 1'b0;
    chk(32'(bresp), 32'h0);
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50 && (n == 0 || !arready); n++) @(posedge aclk);
    arvalid <= 1'b0;
    for (n = 0; n < 50 && !rvalid; n++) @(posedge aclk);
    tmo(n);
    d = rdata;
    rready <= 1'b0;
    chk(32'(rresp), 32'h0);
  endtask

  task automatic model_cmd(input logic [7:0] c, l, input logic [31:0] bd, output int rf, code);
    int b0, b2, b3, hi, lo;
    b0 = bd[7:0];
    b2 = bd[23:16];
    b3 = bd[31:24];
    hi = b3 / 16;
    lo = b3 % 16;
    rf = c == 8'h09 && l != 8'h03 && l != 8'h04;
    if (c == 8'h09 && l == 8'h04 && b0 == 8'h68 && b2 == 1 && !(lo inside {0, 1, 3, 7, 15}
        && (m_proto == 2 ? hi == 13 : m_proto == 3 ? hi >= 1 && hi <= 4 : 1)))
      rf = 1;
    if (c == 8'h09 && l == 8'h04 && b0 == 8'h3a && (b2 < 8'h50 || b2 > 8'h60)) rf = 1;
    code = 8'h82;
    if (rf) return;
    if (c == 8'h02 && l >= 2 && b0 >= 1 && b0 <= 4) begin
      code = 0;
      m_proto = b0;
      m_win = 8'h52;
      m_filt = 0;
      m_cut = 0;
      m_an = b0 == 2 ? 8'hdf : b0 == 3 ? 8'h2f : b0 == 4 ? 8'h5f : bd[12] ? 8'h53 : 8'hd3;
    end
    if (c == 8'h09 && (l == 8'h03 || l == 8'h04) && b0 == 8'h68) code = 0;
    if (c == 8'h09 && l == 8'h04 && b0 == 8'h68 && b2 == 1) m_an = b3;
    if (c == 8'h09 && l == 8'h04 && b0 == 8'h68 && b2 == 7) m_cut = hi % 2;
    if (c == 8'h09 && l == 8'h04 && b0 == 8'h3a && b3 == 8'h04) begin
      code = 0;
      m_win = b2;
    end
    if (c == 8'h09 && l == 8'h04 && b0 == 8'h0a && b3 == 8'ha1) begin
      code = 0;
      m_filt = b2 == 2;
    end
  endtask

  // one command through the register port, then every visible result against the model
  task automatic run_cmd(input logic [7:0] c, l, input logic [31:0] body);
    int n, rf, code;
    logic [31:0] st;
    model_cmd(c, l, body, rf, code);
    axi_wr(RFT_REG_DATA, body);
    axi_wr(RFT_REG_CMD, {16'h0, l, c});
    axi_wr(RFT_REG_CTRL, 32'h1);
    st = 0;
    for (n = 0; n < 50 && st[2:1] == 2'b00; n++) axi_rd(RFT_REG_STATUS, st);
    tmo(n);
    chk({29'h0, st[2:0]}, rf ? 32'h4 : 32'h2);
    if (!rf) chk({16'h0, st[23:8]}, 32'(code));
    chk(32'(an), 32'(m_an));
    chk(32'(win), 32'(m_win));
    chk(32'(filt), 32'(m_filt));
    chk(32'({cut, rmode}), m_cut ? 32'h2 : 32'h1);
    chk(32'(prot), 32'(m_proto));
  endtask

  task automatic raw_frame;
    int n;
    @(posedge aclk);
    foreach (q[j]) begin
      link2.cmd_valid <= 1'b1;
      link2.cmd_byte <= q[j];
      for (n = 0; n < 50 && (n == 0 || !link2.cmd_ready); n++) @(posedge aclk);
      tmo(n);
    end
    link2.cmd_valid <= 1'b0;
    link2.cmd_byte <= ~q[q.size() - 1];
    link2.rsp_ready <= 1'b1;
    for (k = 0; k < 2; k++) begin
      for (n = 0; n < 50 && (n == 0 || !link2.rsp_valid); n++) @(posedge aclk);
      tmo(n);
      chk(32'(link2.rsp_byte), k == 0 ? 32'h82 : 32'h0);
    end
    link2.rsp_ready <= 1'b0;
  endtask

  initial begin
    seed = 8677;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    link2.cmd_valid = 1'b0;
    link2.cmd_byte = 8'h00;
    link2.rsp_ready = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'({an, win, 6'h0, cut, filt}), 32'h00df5200);
    axi_rd(RFT_REG_CTRL, rd);
    chk(rd, 32'h0);
    // dirty the filter, window and cut settings, then show that each select puts them back
    for (i = 0; i < 5; i++) begin
      fl = {$random(seed)} % 2;
      g = {$random(seed)} % 17;
      run_cmd(8'h09, 8'h04, {8'ha1, 8'h02, 8'(fl), 8'h0a});
      run_cmd(8'h09, 8'h04, {8'h04, 8'(8'h50 + g), 8'(fl), 8'h3a});
      run_cmd(8'h09, 8'h04, {8'h10, 8'h07, 8'(fl), 8'h68});
      run_cmd(8'h02, 8'h02, {16'h0, pp[i], pr[i]});
    end
    run_cmd(8'h02, 8'h02, 32'h0000_0002);
    for (i = 0; i < 5; i++) begin
      run_cmd(8'h09, 8'h04, {8'hd0 | gains[i], 8'h01, 8'(fl), 8'h68});
      run_cmd(8'h09, 8'h04, {8'h30 | gains[i], 8'h01, 8'h00, 8'h68});
    end
    run_cmd(8'h09, 8'h04, 32'hd201_0068);
    run_cmd(8'h02, 8'h02, 32'h0000_0003);
    for (i = 0; i < 6; i++) begin
      run_cmd(8'h09, 8'h04, {8'(i * 16) | gains[{$random(seed)} % 5], 8'h01, 8'h00, 8'h68});
    end
    run_cmd(8'h09, 8'h04, 32'h044f_003a);
    run_cmd(8'h09, 8'h04, 32'h0461_003a);
    run_cmd(8'h09, 8'h04, 32'h0460_013a);
    run_cmd(8'h09, 8'h04, 32'h0556_003a);
    run_cmd(8'h09, 8'h04, 32'ha100_000a);
    run_cmd(8'h09, 8'h04, 32'h1007_0068);
    run_cmd(8'h09, 8'h04, 32'h0007_0068);
    run_cmd(8'h09, 8'h03, 32'h0001_0068);
    run_cmd(8'h02, 8'h02, 32'h0000_0005);
    // lengths the host side would refuse go straight onto the second link
    foreach (bad_len[j]) begin
      q = '{8'h09, bad_len[j]};
      for (k = 0; k < bad_len[j]; k++) q.push_back(k == 0 ? 8'h3a : 8'h58);
      raw_frame();
      chk(32'({an2, win2}), 32'h0000df52);
    end
    complete_run();
  end
endmodule
`default_nettype wire
